// [include/ics_params.svh]
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH

// Register byte offsets.
`define ICS_HDR    8'h00
`define ICS_ARG    8'h04
`define ICS_GO     8'h08
`define ICS_RESP   8'h0c
`define ICS_STB    8'h10
`define ICS_ESR    8'h14
`define ICS_ENAB   8'h18
`define ICS_EVT    8'h1c
`define ICS_FLAGS  8'h20
`define ICS_SET    8'h24
`define ICS_PRESET 8'h28
`define ICS_SUMEN  8'h2c

// Field positions.
`define ICS_GO_QRY    0
`define ICS_PR_SYS    0
`define ICS_PR_PATH   1
`define ICS_PR_DEV    2
`define ICS_PR_FACT   3
`define ICS_ESR_OPC   0
`define ICS_ESR_CME   5
`define ICS_ESR_PON   7
`define ICS_STB_QUES  3
`define ICS_STB_MAV   4
`define ICS_STB_ESB   5
`define ICS_STB_MSS   6
`define ICS_STB_OPER  7

// Values.
`define ICS_ESR_RST   8'h80
`define ICS_SRE_MASK  8'hbf
`define ICS_BYTE_MAX  32'd255
`define ICS_OPC_ONE   32'd1
`define ICS_STAR      8'h2a
`define ICS_LC_A      8'h61
`define ICS_LC_Z      8'h7a
`define ICS_LC_BIT    8'h20
`define ICS_UC_MASK   8'hdf

// Command headers, three upper-case letters.
`define ICS_H_CLS 24'h434c53
`define ICS_H_ESE 24'h455345
`define ICS_H_ESR 24'h455352
`define ICS_H_IDN 24'h49444e
`define ICS_H_IST 24'h495354
`define ICS_H_OPC 24'h4f5043
`define ICS_H_OPT 24'h4f5054
`define ICS_H_PRE 24'h505245
`define ICS_H_PSC 24'h505343
`define ICS_H_RCL 24'h52434c
`define ICS_H_RST 24'h525354
`define ICS_H_SAV 24'h534156
`define ICS_H_SRE 24'h535245
`define ICS_H_STB 24'h535442
`define ICS_H_TRG 24'h545247
`define ICS_H_TST 24'h545354
`define ICS_H_WAI 24'h574149

`endif

// [include/ics_pkg.sv]
package ics_pkg;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ics_wb_req_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_EXEC = 4'b0010,
    S_WOPS = 4'b0100,
    S_WTST = 4'b1000
  } ics_state_t;

  typedef enum logic [4:0] {
    C_BAD, C_CLS, C_ESE, C_ESR, C_IDN, C_IST,
    C_OPC, C_OPT, C_PRE, C_PSC, C_RCL, C_RST,
    C_SAV, C_SRE, C_STB, C_TRG, C_TST, C_WAI
  } ics_cmd_t;

endpackage : ics_pkg

// [src/ics_common_status.sv]
// What this block does
// - Clear status zeroes status byte, event registers, output buffer; masks kept.
// - A command header is an asterisk and exactly three letters.
// - Event enable loads 0..255; query returns it.
// - Event read returns the event register, then clears it.
// - Individual status query returns the parallel poll bit, 0 or 1.
// - Operation complete sets event bit 0 after earlier work ends.
// - Operation complete query answers 1 after earlier work ends.
// - Option query returns fixed positions, zero where not installed.
// - Parallel poll enable loads 0..255; query returns it.
// - Power-on clear flag decides whether enables survive power-on; a cold start clears them regardless, the flag acts only at a warm reset.
// - Save copies current settings into the numbered slot.
// - Recall loads and activates settings from the numbered slot.
// - Reset restores defaults, same as the system preset.
// - Reset keeps the settings that integrate the instrument.
// - Service request enable loads 0..255; bit 6 reads 0.
// - Status byte query returns the status byte; query only.
// - Trigger reaches every function waiting for a trigger.
// - Self-test query returns 0 or a positive error code.
// - Wait holds later commands until work ends and signals settle.
// - Signal path preset presets only the signal path part.
// - Device preset presets every part not tied to the path.
// - Factory restore keeps password-protected parts.
//
// Added by the designer: the Wishbone slave port and the address map.
`include "ics_params.svh"

module ics_common_status
  import ics_pkg::*;
#(
  parameter int                NSLOT       = 10,
  parameter int                SET_W       = 32,
  parameter int                NTRIG       = 4,
  parameter logic [SET_W-1:0]  PRESET_VAL  = '0,
  parameter logic [SET_W-1:0]  FACTORY_VAL = '0,
  parameter logic [SET_W-1:0]  INTEG_MASK  = '0,
  parameter logic [SET_W-1:0]  PATH_MASK   = '0,
  parameter logic [SET_W-1:0]  PROT_MASK   = '0,
  // Identity word; the value is arbitrary.
  parameter logic [31:0]       IDN_CODE    = 32'h0000_0001
) (
  input  wire logic              clock,
  input  wire logic              clk_en,
  input  wire logic              rst_b,
  input  wire logic              cold_start,
  input  wire ics_wb_req_t       wb,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              ops_busy,
  input  wire logic              signals_settled,
  input  wire logic [15:0]       ques_event,
  input  wire logic [15:0]       oper_event,
  input  wire logic [31:0]       options_in,
  input  wire logic [NTRIG-1:0]  trig_waiting,
  output logic [NTRIG-1:0]       trig_out,
  output logic                   selftest_start,
  input  wire logic              selftest_done,
  input  wire logic [15:0]       selftest_code,
  output logic [SET_W-1:0]       settings,
  output logic                   settings_load,
  output logic                   ist
);

  localparam int SW = (NSLOT > 1) ? $clog2(NSLOT) : 1;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] ics_merge(
    input logic [31:0] o,
    input logic [31:0] d,
    input logic [3:0]  s
  );
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i+:8] = d[8*i+:8];
    end
    return r;
  endfunction : ics_merge

  // Header check and lookup; letters are taken in either case.
  function automatic ics_cmd_t ics_decode(input logic [31:0] h);
    logic [23:0] u;
    logic        good;
    logic [7:0]  c;
    ics_cmd_t    r;
    good = (h[31:24] == `ICS_STAR);
    u    = '0;
    for (int i = 0; i < 3; i++) begin
      c = h[8*i+:8] | `ICS_LC_BIT;
      good = good & (c >= `ICS_LC_A) & (c <= `ICS_LC_Z);
      u[8*i+:8] = h[8*i+:8] & `ICS_UC_MASK;
    end
    r = C_BAD;
    if (good) begin
      case (u)
        `ICS_H_CLS: r = C_CLS;
        `ICS_H_ESE: r = C_ESE;
        `ICS_H_ESR: r = C_ESR;
        `ICS_H_IDN: r = C_IDN;
        `ICS_H_IST: r = C_IST;
        `ICS_H_OPC: r = C_OPC;
        `ICS_H_OPT: r = C_OPT;
        `ICS_H_PRE: r = C_PRE;
        `ICS_H_PSC: r = C_PSC;
        `ICS_H_RCL: r = C_RCL;
        `ICS_H_RST: r = C_RST;
        `ICS_H_SAV: r = C_SAV;
        `ICS_H_SRE: r = C_SRE;
        `ICS_H_STB: r = C_STB;
        `ICS_H_TRG: r = C_TRG;
        `ICS_H_TST: r = C_TST;
        `ICS_H_WAI: r = C_WAI;
        default:    r = C_BAD;
      endcase
    end
    return r;
  endfunction : ics_decode

  ////////////////////////////////////////////////////////////////////////
  // State.

  ics_state_t       state;
  ics_cmd_t         cmd;
  logic             qry;
  logic [31:0]      hdr;
  logic [31:0]      arg;
  logic [7:0]       ese;
  logic [7:0]       sre;
  logic [7:0]       pre;
  logic             psc;
  logic [7:0]       esr;
  logic [15:0]      ques_evt;
  logic [15:0]      oper_evt;
  logic [15:0]      ques_en;
  logic [15:0]      oper_en;
  logic [31:0]      resp;
  logic             resp_v;
  logic [SET_W-1:0] slot_mem [NSLOT];

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  logic       req;
  logic       go_adr;
  logic       stall;
  logic       wr;
  logic [7:0] wa;

  assign req    = wb.cyc & wb.stb;
  assign go_adr = wb.we & (wb.adr == `ICS_GO);
  // A new command waits in the bus cycle until the previous one ends.
  assign stall  = go_adr & (state != S_IDLE);
  // Writes land on the edge where the master sees ack.
  assign wr     = req & wb.we & wb_ack_o;
  assign wa     = wb.adr;

  // One-cycle ack, dropped the cycle after it was given.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= req & ~wb_ack_o & ~stall;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command qualification.

  logic        ex;
  logic        bad;
  logic        ok;
  logic        qonly;
  logic        sonly;
  logic        ops_ok;
  logic        wdone;
  logic        tdone;
  logic [7:0]  stb;
  logic [31:0] qval;
  logic        pr_sys;
  logic        pr_path;
  logic        pr_dev;
  logic        pr_fact;
  logic        cls;

  assign ex    = (state == S_EXEC);
  assign qonly = cmd inside {C_ESR, C_IDN, C_IST, C_OPT, C_STB, C_TST};
  assign sonly = cmd inside {C_CLS, C_RST, C_TRG, C_WAI, C_RCL, C_SAV};
  // Out-of-range arguments and wrong forms raise a command error.
  assign bad   = (cmd == C_BAD) | (qonly & ~qry) | (sonly & qry)
               | (cmd inside {C_ESE, C_PRE, C_SRE} & ~qry
                  & (arg > `ICS_BYTE_MAX))
               | (cmd inside {C_RCL, C_SAV} & (arg >= 32'(NSLOT)));
  assign ok    = ex & ~bad;
  assign cls   = ok & (cmd == C_CLS);
  // Wait also needs settled outputs; operation complete does not.
  assign ops_ok = ~ops_busy & ((cmd != C_WAI) | signals_settled);
  assign wdone  = (state == S_WOPS) & ops_ok;
  assign tdone  = (state == S_WTST) & selftest_done;

  // Preset requests from the preset register.
  assign pr_sys  = wr & (wa == `ICS_PRESET) & wb.sel[0]
                 & wb.dat[`ICS_PR_SYS];
  assign pr_path = wr & (wa == `ICS_PRESET) & wb.sel[0]
                 & wb.dat[`ICS_PR_PATH];
  assign pr_dev  = wr & (wa == `ICS_PRESET) & wb.sel[0]
                 & wb.dat[`ICS_PR_DEV];
  assign pr_fact = wr & (wa == `ICS_PRESET) & wb.sel[0]
                 & wb.dat[`ICS_PR_FACT];

  // Status byte; the summary is built from the other seven bits.
  always_comb begin
    stb = '0;
    stb[`ICS_STB_QUES] = |(ques_evt & ques_en);
    stb[`ICS_STB_MAV]  = resp_v;
    stb[`ICS_STB_ESB]  = |(esr & ese);
    stb[`ICS_STB_OPER] = |(oper_evt & oper_en);
    stb[`ICS_STB_MSS]  = |(stb & sre);
  end

  assign ist = |(stb & pre);

  // Immediate query answers.
  always_comb begin
    qval = '0;
    case (cmd)
      C_ESE:   qval = {24'h0, ese};
      C_ESR:   qval = {24'h0, esr};
      C_IDN:   qval = IDN_CODE;
      C_IST:   qval = {31'h0, ist};
      C_OPT:   qval = options_in;
      C_PRE:   qval = {24'h0, pre};
      C_PSC:   qval = {31'h0, psc};
      C_SRE:   qval = {24'h0, sre};
      C_STB:   qval = {24'h0, stb};
      default: qval = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= S_IDLE;
      cmd   <= C_BAD;
      qry   <= 1'b0;
    end else if (clk_en) begin
      case (state)
        S_IDLE: begin
          if (wr & (wa == `ICS_GO)) begin
            cmd   <= ics_decode(hdr);
            qry   <= wb.dat[`ICS_GO_QRY];
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (ok & (cmd inside {C_OPC, C_WAI})) begin
            state <= S_WOPS;
          end else if (ok & (cmd == C_TST)) begin
            state <= S_WTST;
          end else begin
            state <= S_IDLE;
          end
        end
        S_WOPS: begin
          if (ops_ok) state <= S_IDLE;
        end
        S_WTST: begin
          if (selftest_done) state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Header and argument registers written by software.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hdr <= '0;
      arg <= '0;
    end else if (clk_en) begin
      if (wr & (wa == `ICS_HDR)) hdr <= ics_merge(hdr, wb.dat, wb.sel);
      if (wr & (wa == `ICS_ARG)) arg <= ics_merge(arg, wb.dat, wb.sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable registers; cleared on a cold start, and on a warm reset only with the clear flag set.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      if (cold_start) psc <= 1'b1;
      if (cold_start | psc) begin
        ese     <= '0;
        sre     <= '0;
        pre     <= '0;
        ques_en <= '0;
        oper_en <= '0;
      end
    end else if (clk_en) begin
      if (ok & ~qry) begin
        case (cmd)
          C_ESE:   ese <= arg[7:0];
          C_PRE:   pre <= arg[7:0];
          C_SRE:   sre <= arg[7:0] & `ICS_SRE_MASK;
          C_PSC:   psc <= |arg;
          default: ;
        endcase
      end
      // Clear status leaves these masks alone.
      if (wr & (wa == `ICS_SUMEN)) begin
        {oper_en, ques_en} <= ics_merge({oper_en, ques_en}, wb.dat, wb.sel);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event registers; a set in the clearing cycle survives.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      esr <= `ICS_ESR_RST;
    end else if (clk_en) begin
      esr <= ((cls | (ok & (cmd == C_ESR))) ? 8'h00 : esr)
           | {2'b00, ex & bad, 4'h0,
              wdone & (cmd == C_OPC) & ~qry};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ques_evt <= '0;
      oper_evt <= '0;
    end else if (clk_en) begin
      ques_evt <= (cls ? 16'h0 : ques_evt) | ques_event;
      oper_evt <= (cls ? 16'h0 : oper_evt) | oper_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-word output buffer; reading the answer register pops it.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      resp   <= '0;
      resp_v <= 1'b0;
    end else if (clk_en) begin
      if (cls | (req & ~wb.we & wb_ack_o & (wa == `ICS_RESP))) begin
        resp_v <= 1'b0;
      end
      if (ok & qry & ~(cmd inside {C_OPC, C_TST})) begin
        resp   <= qval;
        resp_v <= 1'b1;
      end else if (wdone & (cmd == C_OPC) & qry) begin
        resp   <= `ICS_OPC_ONE;
        resp_v <= 1'b1;
      end else if (tdone) begin
        resp   <= {16'h0, selftest_code};
        resp_v <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings, slots and presets.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      settings      <= PRESET_VAL;
      settings_load <= 1'b0;
    end else if (clk_en) begin
      settings_load <= 1'b1;
      if (ok & (cmd == C_RCL)) begin
        settings <= slot_mem[arg[SW-1:0]];
      end else if ((ok & (cmd == C_RST)) | pr_sys) begin
        settings <= (PRESET_VAL & ~INTEG_MASK)
                  | (settings & INTEG_MASK);
      end else if (pr_fact) begin
        settings <= (FACTORY_VAL & ~PROT_MASK)
                  | (settings & PROT_MASK);
      end else if (pr_path) begin
        settings <= (PRESET_VAL & PATH_MASK)
                  | (settings & ~PATH_MASK);
      end else if (pr_dev) begin
        settings <= (PRESET_VAL & ~PATH_MASK)
                  | (settings & PATH_MASK);
      end else begin
        settings_load <= 1'b0;
        if (wr & (wa == `ICS_SET)) begin
          settings <= SET_W'(ics_merge(32'(settings), wb.dat, wb.sel));
          settings_load <= 1'b1;
        end
      end
    end
  end

  // Slots start at the preset value so a recall never loads unknowns.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int i = 0; i < NSLOT; i++) slot_mem[i] <= PRESET_VAL;
    end else if (clk_en & ok & (cmd == C_SAV)) begin
      slot_mem[arg[SW-1:0]] <= settings;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger and self-test strobes.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      trig_out       <= '0;
      selftest_start <= 1'b0;
    end else if (clk_en) begin
      trig_out <= (ok & (cmd == C_TRG)) ? trig_waiting : '0;
      selftest_start <= ok & (cmd == C_TST);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, captured the cycle before ack; unmapped reads give zero.

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (clk_en & req & ~wb_ack_o) begin
      case (wa)
        `ICS_HDR:   wb_dat_o <= hdr;
        `ICS_ARG:   wb_dat_o <= arg;
        `ICS_RESP:  wb_dat_o <= resp;
        `ICS_STB:   wb_dat_o <= {24'h0, stb};
        `ICS_ESR:   wb_dat_o <= {24'h0, esr};
        `ICS_ENAB:  wb_dat_o <= {8'h0, pre, sre, ese};
        `ICS_EVT:   wb_dat_o <= {oper_evt, ques_evt};
        `ICS_FLAGS: wb_dat_o <= {28'h0, psc, ist, resp_v,
                                 state != S_IDLE};
        `ICS_SET:   wb_dat_o <= 32'(settings);
        `ICS_SUMEN: wb_dat_o <= {oper_en, ques_en};
        default:    wb_dat_o <= '0;
      endcase
    end
  end

endmodule : ics_common_status

// [test/ics_instr_model.sv]
module ics_instr_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        work,
  input  wire logic [15:0] code_in,
  input  wire logic        selftest_start,
  output logic             ops_busy,
  output logic             signals_settled,
  output logic             selftest_done,
  output logic [15:0]      selftest_code
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [5:0] busy_cnt;
  logic [5:0] test_cnt;

  // A work request keeps the instrument busy for forty cycles, long enough
  // for the bench to look at the block while earlier work is still running.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy_cnt <= 6'h00;
    end else if (work) begin
      busy_cnt <= 6'h28;
    end else if (busy_cnt != 6'h00) begin
      busy_cnt <= busy_cnt - 6'h01;
    end
  end

  // Outputs settle only once the work is over.
  assign ops_busy        = (busy_cnt != 6'h00);
  assign signals_settled = (busy_cnt == 6'h00);

  ////////////////////////////////////////////////////////////////////////////
  // The self-test takes thirty cycles; the code is only valid with done,
  // otherwise its inverse is shown so a late sample cannot pass.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      test_cnt <= 6'h00;
    end else if (selftest_start) begin
      test_cnt <= 6'h1e;
    end else if (test_cnt != 6'h00) begin
      test_cnt <= test_cnt - 6'h01;
    end
  end

  assign selftest_done = (test_cnt == 6'h01);
  assign selftest_code = selftest_done ? code_in : ~code_in;
endmodule : ics_instr_model

// [test/ics_common_status_checker.sv]
`include "ics_params.svh"

module ics_common_status_checker
  import ics_pkg::*;
#(
  parameter int NTRIG = 4,
  parameter int SET_W = 32
) (
  input wire logic             clock,
  input wire logic             clk_en,
  input wire logic             rst_b,
  input wire ics_wb_req_t      wb,
  input wire logic             wb_ack_o,
  input wire logic [NTRIG-1:0] trig_waiting,
  input wire logic [NTRIG-1:0] trig_out,
  input wire logic             selftest_start,
  input wire logic             settings_load
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge clock); endclocking
  // A frozen clock enable stalls everything, so checks pause with it.
  default disable iff (!rst_b || !clk_en);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one ack per request, never outside a request.
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack lasted more than one cycle");
  a_ack_held: assert property (wb_ack_o |-> wb.cyc && wb.stb)
    else $error("ack without a request");
  a_ack_prompt: assert property (
    $rose(wb.cyc && wb.stb) && wb.adr != `ICS_GO |=> wb_ack_o)
    else $error("register access not answered next cycle");
  a_ack_gone: assert property ($fell(wb.stb) |-> !wb_ack_o)
    else $error("ack after request released");

  // Strobes toward the instrument are single pulses.
  a_trig_copy: assert property (
    |trig_out |-> trig_out == $past(trig_waiting))
    else $error("trigger missed a waiting function");
  a_trig_pulse: assert property (|trig_out |=> trig_out == '0)
    else $error("trigger longer than one cycle");
  a_test_pulse: assert property (
    selftest_start |=> !selftest_start [*2])
    else $error("self-test start repeated");
  a_load_pulse: assert property (settings_load |=> !settings_load)
    else $error("settings load longer than one cycle");
endmodule : ics_common_status_checker

bind ics_common_status ics_common_status_checker #(
  .NTRIG(NTRIG),
  .SET_W(SET_W)
) u_checker (
  .clock(clock), .clk_en(clk_en), .rst_b(rst_b), .wb(wb),
  .wb_ack_o(wb_ack_o), .trig_waiting(trig_waiting), .trig_out(trig_out),
  .selftest_start(selftest_start), .settings_load(settings_load)
);

// [test/testbench.sv]
`include "ics_params.svh"

module testbench
  import ics_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] PV = 32'h0000_00a5;
  localparam logic [31:0] FV = 32'h5a5a_5a5a;
  localparam logic [31:0] IM = 32'hff00_0000;
  localparam logic [31:0] PM = 32'h00ff_0000;
  localparam logic [31:0] KM = 32'h0000_f000;
  localparam logic [31:0] OPTS = 32'h0003_0100;

  logic        clock = 1'b0, rst_b = 1'b0, work = 1'b0, cold = 1'b1;
  logic        wb_ack_o, ops_busy, signals_settled, selftest_start;
  logic        selftest_done, settings_load, ist, busy_at_trig = 1'b1;
  logic [15:0] code = 16'h0000, qev = 16'h0000, selftest_code;
  logic [31:0] wb_dat_o, settings;
  logic [3:0]  trig_waiting = 4'h5, trig_out, trig_seen = 4'h0;
  ics_wb_req_t wb = '0;
  int          num_errors = 0, samples_checked = 0, ld_cnt = 0;

  ics_common_status #(.PRESET_VAL(PV), .FACTORY_VAL(FV), .INTEG_MASK(IM),
    .PATH_MASK(PM), .PROT_MASK(KM)) uut (
    .clock(clock), .clk_en(1'b1), .rst_b(rst_b), .cold_start(cold),
    .wb(wb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ops_busy(ops_busy), .signals_settled(signals_settled),
    .ques_event(qev), .oper_event(16'h0000), .options_in(OPTS),
    .trig_waiting(trig_waiting), .trig_out(trig_out),
    .selftest_start(selftest_start), .selftest_done(selftest_done),
    .selftest_code(selftest_code), .settings(settings),
    .settings_load(settings_load), .ist(ist));

  ics_instr_model u_model (.clock(clock), .rst_b(rst_b), .work(work),
    .code_in(code), .selftest_start(selftest_start), .ops_busy(ops_busy),
    .signals_settled(signals_settled), .selftest_done(selftest_done),
    .selftest_code(selftest_code));

  always #5 clock = ~clock;

  // Strobe pulses are too short for a bus task to see, so latch them here.
  always @(posedge clock) begin
    if (|trig_out) begin
      trig_seen <= trig_out;
      busy_at_trig <= ops_busy;
    end
    if (settings_load) ld_cnt <= ld_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // One classic cycle; the wait for ack is bounded so a stuck slave counts.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 600);
    if (n >= 600) num_errors++;
    q = wb_dat_o;
    wb <= '0;
    @(posedge clock);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // A wrong lead character gives a header that must be refused.
  task automatic cmd(input logic [23:0] h, input logic [31:0] arg,
                     input logic qry, input logic bad);
    wr(`ICS_HDR, {bad ? 8'h23 : `ICS_STAR, h});
    wr(`ICS_ARG, arg);
    wr(`ICS_GO, {31'h0, qry});
  endtask : cmd

  task automatic get(input logic [31:0] e);
    int n;
    logic [31:0] q;
    n = 0;
    q = 32'h0;
    while (!q[1] && n < 100) begin
      bus(1'b0, `ICS_FLAGS, 32'h0, q);
      n++;
    end
    if (!q[1]) num_errors++;
    rd(`ICS_RESP, e);
  endtask : get

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    rd(`ICS_ESR, 32'h80);
    cmd(`ICS_H_ESR, 0, 1'b1, 1'b0);
    get(32'h80);
    rd(`ICS_ESR, 32'h0);
    cmd(`ICS_H_ESE, 0, 1'b0, 1'b1);
    rd(`ICS_ESR, 32'h20);
    cmd(`ICS_H_OPT, 0, 1'b1, 1'b0);
    qev <= 16'h0004;
    @(posedge clock);
    qev <= 16'h0000;
    rd(`ICS_EVT, 32'h4);
    cmd(`ICS_H_CLS, 0, 1'b0, 1'b0);
    rd(`ICS_ESR, 32'h0);
    rd(`ICS_EVT, 32'h0);
    rd(`ICS_FLAGS, 32'h8);
    cmd(`ICS_H_OPT, 0, 1'b1, 1'b0);
    get(OPTS);
    cmd(`ICS_H_STB, 0, 1'b1, 1'b0);
    get(32'h0);
  endtask : t_status

  task automatic t_enab();
    cmd(`ICS_H_ESE, 32'h20, 1'b0, 1'b0);
    cmd(`ICS_H_SRE, 32'hff, 1'b0, 1'b0);
    cmd(`ICS_H_PRE, 32'h3c, 1'b0, 1'b0);
    cmd(`ICS_H_ESE, 0, 1'b1, 1'b0);
    get(32'h20);
    cmd(`ICS_H_ESE, 32'h100, 1'b0, 1'b0);
    rd(`ICS_ESR, 32'h20);
    rd(`ICS_STB, 32'h60);
    cmd(`ICS_H_IST, 0, 1'b1, 1'b0);
    get(32'h1);
    chk({31'h0, ist}, 32'h1);
    cmd(`ICS_H_PRE, 0, 1'b1, 1'b0);
    get(32'h3c);
    cmd(`ICS_H_PSC, 0, 1'b0, 1'b0);
    cmd(`ICS_H_PSC, 0, 1'b1, 1'b0);
    get(32'h0);
    cmd(`ICS_H_CLS, 0, 1'b0, 1'b0);
    rd(`ICS_ENAB, 32'h3c_bf20);
    // A warm restart with the clear flag off must keep every enable.
    cold <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(`ICS_ENAB, 32'h3c_bf20);
    cmd(`ICS_H_CLS, 0, 1'b0, 1'b0);
  endtask : t_enab

  // Earlier work is kept running by the model while the block must wait.
  task automatic t_sync();
    work <= 1'b1;
    @(posedge clock);
    work <= 1'b0;
    cmd(`ICS_H_OPC, 0, 1'b0, 1'b0);
    rd(`ICS_ESR, 32'h0);
    cmd(`ICS_H_OPC, 0, 1'b1, 1'b0);
    get(32'h1);
    rd(`ICS_ESR, 32'h1);
    work <= 1'b1;
    @(posedge clock);
    work <= 1'b0;
    cmd(`ICS_H_WAI, 0, 1'b0, 1'b0);
    cmd(`ICS_H_TRG, 0, 1'b0, 1'b0);
    rd(`ICS_ESR, 32'h1);
    chk({28'h0, trig_seen}, 32'h5);
    chk({31'h0, busy_at_trig}, 32'h0);
    cmd(`ICS_H_CLS, 0, 1'b0, 1'b0);
  endtask : t_sync

  task automatic t_tst();
    for (int i = 0; i < 2; i++) begin
      code <= i ? 16'h0007 : 16'h0000;
      cmd(`ICS_H_TST, 0, 1'b1, 1'b0);
      get(i ? 32'h7 : 32'h0);
    end
  endtask : t_tst

  task automatic t_store();
    int c0;
    wr(`ICS_SET, 32'hc3c3_1234);
    cmd(`ICS_H_SAV, 32'h3, 1'b0, 1'b0);
    wr(`ICS_SET, 32'h0);
    // Let the load pulse of that write be counted before taking the base.
    @(posedge clock);
    c0 = ld_cnt;
    cmd(`ICS_H_RCL, 32'h3, 1'b0, 1'b0);
    rd(`ICS_SET, 32'hc3c3_1234);
    chk(settings, 32'hc3c3_1234);
    chk(32'(ld_cnt - c0), 32'h1);
    cmd(`ICS_H_SAV, 32'ha, 1'b0, 1'b0);
    rd(`ICS_ESR, 32'h20);
    cmd(`ICS_H_CLS, 0, 1'b0, 1'b0);
  endtask : t_store

  // Start from all ones so every kept bit is visible after each preset.
  task automatic t_preset();
    logic [31:0] ex [5];
    ex = '{IM | (PV & ~IM), ~PM | (PV & PM), PM | (PV & ~PM),
           KM | (FV & ~KM), IM | (PV & ~IM)};
    for (int i = 0; i < 5; i++) begin
      wr(`ICS_SET, 32'hffff_ffff);
      if (i < 4) wr(`ICS_PRESET, 32'h1 << i);
      else cmd(`ICS_H_RST, 0, 1'b0, 1'b0);
      rd(`ICS_SET, ex[i]);
    end
  endtask : t_preset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_status();
    t_enab();
    t_sync();
    t_tst();
    t_store();
    t_preset();
    close_out();
  end

  // The tests need under a thousand cycles; this limit is far beyond that.
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    close_out();
  end
endmodule : testbench
